/* File: verilog/swgf_pkg.sv */
// Shared constants and types for the switch grant and flow signalling block
`default_nettype none
package swgf_pkg;
  localparam int LANES = 8;
  localparam int GRANT_W = 2;
  localparam int PRIO_N = 3;
  localparam int CONN_N = 2;
  localparam int STATUS_SLOTS = 16;
  localparam int SPACE_W = 8;
  localparam int RATE_W = 16;
  // Multicast grant codes
  localparam logic [1:0] MC_NONE = 2'h0;
  localparam logic [1:0] MC_P01 = 2'h1;
  localparam logic [1:0] MC_P2 = 2'h2;
  localparam logic [1:0] MC_ALL = 2'h3;
  // Multicast grant bit positions
  localparam int MC_HI_BIT = 0;
  localparam int MC_LO_BIT = 1;
  // Priority masks, bit n set when priority n may be sent
  localparam logic [2:0] PRIO_MASK_NONE = 3'h0;
  localparam logic [2:0] PRIO_MASK_P01 = 3'h3;
  localparam logic [2:0] PRIO_MASK_P2 = 3'h4;
  localparam logic [2:0] PRIO_MASK_ALL = 3'h7;
  localparam logic [1:0] PRIO_LOW = 2'h2;
  // Reset values
  localparam logic [7:0] LANE_IDLE = 8'h00;
  localparam logic [1:0] GRANT_RST = 2'h0;
  localparam logic SEND_GRANT_RST = 1'b0;
  localparam logic [3:0] SLOT_RST = 4'h0;
  // Unicast grant interpretation
  typedef enum logic {UC_SPLIT, UC_COMBINED} swgf_uc_mode_t;
endpackage
`default_nettype wire

/* File: verilog/swgf_grant_if.sv */
// Decoded grant state passed from a grant port to the lane logic
`timescale 1ns/1ps
`default_nettype none
interface swgf_grant_if;
  logic uc_hi;
  logic uc_lo;
  logic mc_hi;
  logic mc_lo;
  logic [2:0] mc_prio;
  modport grant (output uc_hi, output uc_lo, output mc_hi, output mc_lo,
    output mc_prio);
  modport user (input uc_hi, input uc_lo, input mc_hi, input mc_lo,
    input mc_prio);
endinterface
`default_nettype wire

/* File: verilog/swgf_grant_port.sv */
// Grant sampling, decoding and send-grant generation for one connection
`timescale 1ns/1ps
`default_nettype none
module swgf_grant_port (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic grant_tick, // Twice-switch-clock sample strobe
  input wire logic [1:0] unicast_grant, // Unicast grant from fabric
  input wire logic [1:0] multicast_grant, // Multicast grant from fabric
  input wire swgf_pkg::swgf_uc_mode_t uc_mode, // Grant bit meaning
  input wire logic [7:0] rx_space, // Free receive cell slots
  input wire logic [7:0] rx_space_min, // Least slots for able
  output logic send_grant, // High when able to accept cells
  swgf_grant_if.grant gi // Decoded grants
);
  logic [1:0] uc_q, uc_d;
  logic [1:0] mc_q, mc_d;
  logic sg_q, sg_d;

  function automatic logic [2:0] mc_decode(input logic [1:0] code);
    unique case (code)
      swgf_pkg::MC_NONE: mc_decode = swgf_pkg::PRIO_MASK_NONE;
      swgf_pkg::MC_P01: mc_decode = swgf_pkg::PRIO_MASK_P01;
      swgf_pkg::MC_P2: mc_decode = swgf_pkg::PRIO_MASK_P2;
      swgf_pkg::MC_ALL: mc_decode = swgf_pkg::PRIO_MASK_ALL;
    endcase
  endfunction

  // Grants only move on the double-rate strobe
  always_comb
  begin
    uc_d = uc_q;
    mc_d = mc_q;
    sg_d = sg_q;
    if (grant_tick)
    begin
      uc_d = unicast_grant;
      mc_d = multicast_grant;
      sg_d = (rx_space >= rx_space_min);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      uc_q <= swgf_pkg::GRANT_RST;
      mc_q <= swgf_pkg::GRANT_RST;
      sg_q <= swgf_pkg::SEND_GRANT_RST;
    end
    else
    begin
      uc_q <= uc_d;
      mc_q <= mc_d;
      sg_q <= sg_d;
    end
  end

  assign send_grant = sg_q;
  // Combined mode lets bit 0 gate both classes
  assign gi.uc_hi = uc_q[0];
  assign gi.uc_lo = (uc_mode == swgf_pkg::UC_COMBINED) ? uc_q[0] : uc_q[1];
  assign gi.mc_hi = mc_q[swgf_pkg::MC_HI_BIT];
  assign gi.mc_lo = mc_q[swgf_pkg::MC_LO_BIT];
  assign gi.mc_prio = mc_decode(mc_q);
endmodule
`default_nettype wire

/* File: verilog/swgf_lane_port.sv */
// Lane word transmit gating and receive capture for one connection
`timescale 1ns/1ps
`default_nettype none
module swgf_lane_port #(
  parameter int LANES = swgf_pkg::LANES
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic lane_tick, // Eight-times-switch-clock lane strobe
  input wire logic [LANES-1:0] tx_word, // One bit per lane
  input wire logic tx_valid, // Word offered
  input wire logic tx_mc, // Word belongs to a multicast cell
  input wire logic [1:0] tx_prio, // Cell priority 0..2
  output logic tx_ready, // Word taken this cycle
  output logic [LANES-1:0] tx_lanes, // Lane outputs
  input wire logic [LANES-1:0] rx_lanes, // Lane inputs
  output logic [LANES-1:0] rx_word, // Captured lane word
  output logic rx_word_valid, // Pulse per captured word
  swgf_grant_if.user gi // Decoded grants
);
  logic permit;
  logic [LANES-1:0] tx_q, tx_d, rx_q, rx_d;
  logic rv_q, rv_d;

  // Priority 3 does not exist and is never sent
  always_comb
  begin
    permit = 1'b0;
    if (tx_prio <= swgf_pkg::PRIO_LOW)
    begin
      if (tx_mc)
        permit = gi.mc_prio[tx_prio] &
          ((tx_prio == swgf_pkg::PRIO_LOW) ? gi.mc_lo : gi.mc_hi);
      else
        permit = (tx_prio == swgf_pkg::PRIO_LOW) ? gi.uc_lo : gi.uc_hi;
    end
  end

  assign tx_ready = lane_tick & permit;

  always_comb
  begin
    tx_d = tx_q;
    rx_d = rx_q;
    rv_d = 1'b0;
    if (lane_tick)
    begin
      tx_d = (tx_valid & permit) ? tx_word : LANES'(swgf_pkg::LANE_IDLE);
      rx_d = rx_lanes;
      rv_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_q <= LANES'(swgf_pkg::LANE_IDLE);
      rx_q <= LANES'(swgf_pkg::LANE_IDLE);
      rv_q <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      rv_q <= rv_d;
    end
  end

  assign tx_lanes = tx_q;
  assign rx_word = rx_q;
  assign rx_word_valid = rv_q;
endmodule
`default_nettype wire

/* File: verilog/swgf_top.sv */
// Fabric grant, lane, ingress threshold and peer status signalling top
`timescale 1ns/1ps
`default_nettype none
module swgf_top #(
  parameter int LANES = swgf_pkg::LANES,
  parameter int SLOTS = swgf_pkg::STATUS_SLOTS,
  parameter int SPACE_W = swgf_pkg::SPACE_W,
  parameter int RATE_W = swgf_pkg::RATE_W
) (
  input wire logic clock, // 200 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic lane_tick, // Lane bit strobe
  input wire logic grant_tick, // Grant sample strobe
  input wire swgf_pkg::swgf_uc_mode_t uc_mode, // Unicast grant mode
  input wire logic [1:0] unicast_grant_a, // Unicast grant, A
  input wire logic [1:0] unicast_grant_b, // Unicast grant, B
  input wire logic [1:0] multicast_grant_a, // Multicast grant, A
  input wire logic [1:0] multicast_grant_b, // Multicast grant, B
  output logic send_grant_a, // Able to receive on A
  output logic send_grant_b, // Able to receive on B
  input wire logic [SPACE_W-1:0] rx_space_a, // Free receive slots, A
  input wire logic [SPACE_W-1:0] rx_space_b, // Free receive slots, B
  input wire logic [SPACE_W-1:0] rx_space_min, // Slots needed for able
  output logic [LANES-1:0] cell_tx_lanes_a, // Output lanes, A
  output logic [LANES-1:0] cell_tx_lanes_b, // Output lanes, B
  input wire logic [LANES-1:0] cell_rx_lanes_a, // Input lanes, A
  input wire logic [LANES-1:0] cell_rx_lanes_b, // Input lanes, B
  input wire logic [LANES-1:0] tx_word_a, // Lane word to send, A
  input wire logic [LANES-1:0] tx_word_b, // Lane word to send, B
  input wire logic tx_valid_a, // Word offered, A
  input wire logic tx_valid_b, // Word offered, B
  input wire logic tx_mc_a, // Multicast word, A
  input wire logic tx_mc_b, // Multicast word, B
  input wire logic [1:0] tx_prio_a, // Word priority, A
  input wire logic [1:0] tx_prio_b, // Word priority, B
  output logic tx_ready_a, // Word taken, A
  output logic tx_ready_b, // Word taken, B
  output logic [LANES-1:0] rx_word_a, // Received lane word, A
  output logic [LANES-1:0] rx_word_b, // Received lane word, B
  output logic rx_word_valid_a, // Received word pulse, A
  output logic rx_word_valid_b, // Received word pulse, B
  input wire logic [SPACE_W-1:0] free_q_count, // Ingress free buffers
  input wire logic [SPACE_W-1:0] free_q_threshold, // Free queue limit
  output logic ingress_buffers_low, // Free queue threshold exceeded
  input wire logic status_tick, // One status slot per strobe
  input wire logic sync_source, // This device makes the sync
  input wire logic [$clog2(SLOTS)-1:0] my_slot, // Own status slot
  input wire logic [RATE_W-1:0] egress_rate_avg, // Egress rate average
  input wire logic [RATE_W-1:0] egress_rate_limit, // Rate threshold
  input wire logic peer_status_frame_sync_in, // Sync line level
  output logic peer_status_frame_sync_out, // Sync drive value
  output logic peer_status_frame_sync_oe, // Sync driver enable
  input wire logic peer_status_line_in, // Status line level
  output logic peer_status_line_out, // Status drive value
  output logic peer_status_line_oe, // Status driver enable
  output logic [SLOTS-1:0] peer_congested // Last status bit per slot
);
  localparam int SW = $clog2(SLOTS);
  localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);

  logic [1:0][1:0] ucg, mcg, prio;
  logic [1:0][LANES-1:0] txw, txl, rxl, rxw;
  logic [1:0][SPACE_W-1:0] space;
  logic [1:0] sg, txv, txmc, txr, rxv;

  assign ucg = {unicast_grant_b, unicast_grant_a};
  assign mcg = {multicast_grant_b, multicast_grant_a};
  assign prio = {tx_prio_b, tx_prio_a};
  assign txw = {tx_word_b, tx_word_a};
  assign rxl = {cell_rx_lanes_b, cell_rx_lanes_a};
  assign space = {rx_space_b, rx_space_a};
  assign txv = {tx_valid_b, tx_valid_a};
  assign txmc = {tx_mc_b, tx_mc_a};

  // Both connections are identical apart from their pins
  for (genvar c = 0; c < swgf_pkg::CONN_N; c++)
  begin : g_conn
    swgf_grant_if gif ();

    swgf_grant_port u_grant (
      .clock(clock),
      .sys_rst(sys_rst),
      .grant_tick(grant_tick),
      .unicast_grant(ucg[c]),
      .multicast_grant(mcg[c]),
      .uc_mode(uc_mode),
      .rx_space(space[c]),
      .rx_space_min(rx_space_min),
      .send_grant(sg[c]),
      .gi(gif.grant)
    );

    swgf_lane_port #(.LANES(LANES)) u_lane (
      .clock(clock),
      .sys_rst(sys_rst),
      .lane_tick(lane_tick),
      .tx_word(txw[c]),
      .tx_valid(txv[c]),
      .tx_mc(txmc[c]),
      .tx_prio(prio[c]),
      .tx_ready(txr[c]),
      .tx_lanes(txl[c]),
      .rx_lanes(rxl[c]),
      .rx_word(rxw[c]),
      .rx_word_valid(rxv[c]),
      .gi(gif.user)
    );
  end

  assign send_grant_a = sg[0];
  assign send_grant_b = sg[1];
  assign cell_tx_lanes_a = txl[0];
  assign cell_tx_lanes_b = txl[1];
  assign tx_ready_a = txr[0];
  assign tx_ready_b = txr[1];
  assign rx_word_a = rxw[0];
  assign rx_word_b = rxw[1];
  assign rx_word_valid_a = rxv[0];
  assign rx_word_valid_b = rxv[1];

  // Ingress threshold and peer status time-division bus
  logic thr_q, thr_d;
  logic over_q, over_d;
  logic [SW-1:0] slot_q, slot_d;
  logic sync_q, sync_d;
  logic sync_oe_q, sync_oe_d;
  logic line_q, line_d;
  logic line_oe_q, line_oe_d;
  logic [SLOTS-1:0] cong_q, cong_d;
  logic [SW-1:0] next_slot;

  always_comb
  begin
    thr_d = (free_q_count > free_q_threshold);
    over_d = (egress_rate_avg > egress_rate_limit);
    slot_d = slot_q;
    sync_d = 1'b0;
    line_d = line_q;
    line_oe_d = line_oe_q;
    cong_d = cong_q;
    next_slot = (slot_q == LAST_SLOT) ? swgf_pkg::SLOT_RST : slot_q + 1'b1;
    sync_oe_d = sync_source;
    if (status_tick)
    begin
      // Followers realign on each observed sync pulse
      if (!sync_source && peer_status_frame_sync_in)
        slot_d = swgf_pkg::SLOT_RST;
      else
        slot_d = next_slot;
      sync_d = sync_source && (next_slot == swgf_pkg::SLOT_RST);
      line_oe_d = (slot_d == my_slot);
      line_d = (slot_d == my_slot) ? over_q : 1'b0;
      // Record the bit that stood in the slot just ending
      cong_d[slot_q] = peer_status_line_in;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      thr_q <= 1'b0;
      over_q <= 1'b0;
      slot_q <= swgf_pkg::SLOT_RST;
      sync_q <= 1'b0;
      sync_oe_q <= 1'b0;
      line_q <= 1'b0;
      line_oe_q <= 1'b0;
      cong_q <= '0;
    end
    else
    begin
      thr_q <= thr_d;
      over_q <= over_d;
      slot_q <= slot_d;
      sync_q <= sync_d;
      sync_oe_q <= sync_oe_d;
      line_q <= line_d;
      line_oe_q <= line_oe_d;
      cong_q <= cong_d;
    end
  end

  assign ingress_buffers_low = thr_q;
  assign peer_status_frame_sync_out = sync_q & sync_oe_q;
  assign peer_status_frame_sync_oe = sync_oe_q;
  assign peer_status_line_out = line_q & line_oe_q;
  assign peer_status_line_oe = line_oe_q;
  assign peer_congested = cong_q;
endmodule
`default_nettype wire

/* File: tb/swgf_sva.sv */
// Concurrent checks on the grant, lane, threshold and status ports
`timescale 1ns/1ps
`default_nettype none
module swgf_sva (
  input wire logic clock, // Clock
  input wire logic sys_rst, // Reset
  input wire logic lane_tick, // Lane strobe
  input wire logic grant_tick, // Grant strobe
  input wire logic status_tick, // Status slot strobe
  input wire logic rx_word_valid_a, // Received word pulse A
  input wire logic [7:0] rx_space_a, // Free slots A
  input wire logic [7:0] rx_space_min, // Slots for able
  input wire logic send_grant_a, // Able A
  input wire logic [1:0] multicast_grant_a, // Multicast grant A
  input wire logic tx_valid_a, // Offered A
  input wire logic tx_mc_a, // Multicast word A
  input wire logic tx_ready_a, // Taken A
  input wire logic [7:0] cell_tx_lanes_a, // Lanes A
  input wire logic [7:0] free_q_count, // Free buffers
  input wire logic [7:0] free_q_threshold, // Limit
  input wire logic ingress_buffers_low, // Over limit
  input wire logic sync_source, // Sync maker
  input wire logic peer_status_frame_sync_out, // Sync value
  input wire logic peer_status_frame_sync_oe, // Sync enable
  input wire logic peer_status_line_out, // Line value
  input wire logic peer_status_line_oe // Line enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_mc_none;
    grant_tick && multicast_grant_a == swgf_pkg::MC_NONE;
  endsequence
  sequence s_idle_tick;
    lane_tick && !(tx_valid_a && tx_ready_a);
  endsequence
  a_sg_able: assert property (
    grant_tick && rx_space_a >= rx_space_min |=> send_grant_a)
    else $error("send grant low while able");
  a_sg_unable: assert property (
    grant_tick && rx_space_a < rx_space_min |=> !send_grant_a)
    else $error("send grant high while unable");
  a_sg_hold: assert property (
    !grant_tick |=> $stable(send_grant_a))
    else $error("send grant moved off strobe");
  // Looks at a lane strobe two cycles after the no-grant sample, with no grant strobe between
  a_mc_none_block: assert property (
    s_mc_none ##1 !grant_tick ##1 (lane_tick && tx_mc_a) |-> !tx_ready_a)
    else $error("multicast taken without grant");
  a_thr_high: assert property (
    free_q_count > free_q_threshold |=> ingress_buffers_low)
    else $error("threshold flag low");
  a_thr_low: assert property (
    free_q_count <= free_q_threshold |=> !ingress_buffers_low)
    else $error("threshold flag high");
  a_tx_idle: assert property (
    s_idle_tick |=> cell_tx_lanes_a == swgf_pkg::LANE_IDLE)
    else $error("lanes not idle without word");
  a_sync_pulse: assert property (
    peer_status_frame_sync_out |->
      peer_status_frame_sync_oe ##1 !peer_status_frame_sync_out)
    else $error("sync pulse wrong");
  a_sync_src: assert property (
    !sync_source |=> !peer_status_frame_sync_oe)
    else $error("sync enable without source");
  a_line_quiet: assert property (
    !peer_status_line_oe |-> !peer_status_line_out)
    else $error("status line driven outside slot");
  a_line_hold: assert property (
    !status_tick |=> $stable(peer_status_line_oe))
    else $error("status line enable moved inside slot");
  a_rx_valid: assert property (
    lane_tick |=> rx_word_valid_a)
    else $error("no receive pulse after lane strobe");
  a_rx_quiet: assert property (
    !lane_tick |=> !rx_word_valid_a)
    else $error("receive pulse without lane strobe");
endmodule
`default_nettype wire

/* File: tb/swgf_fabric_model.sv */
// Switch fabric stand-in: grant lines and receive lanes of one connection
`timescale 1ns/1ps
`default_nettype none
module swgf_fabric_model (
  input wire logic clock, // Clock
  input wire logic grant_tick, // Grant strobe
  input wire logic [1:0] grant_cmd, // Grant code to show
  input wire logic [7:0] cell_cmd, // Word sent when allowed
  input wire logic send_grant, // Device able
  output logic [1:0] unicast_grant, // Unicast grant
  output logic [1:0] multicast_grant, // Multicast grant
  output logic [7:0] cell_lanes // Lanes to device
);
  initial
  begin
    unicast_grant = 2'h0;
    multicast_grant = 2'h0;
  end
  // Grants move only on the strobe, so the device sees them a tick late
  always @(posedge clock)
    if (grant_tick)
    begin
      unicast_grant <= grant_cmd;
      multicast_grant <= grant_cmd;
    end
  assign cell_lanes = send_grant ? cell_cmd : 8'h00;
endmodule
`default_nettype wire

/* File: tb/swgf_top_tb_top.sv */
// Top testbench for the switch grant and flow signalling block
`timescale 1ns/1ps
`default_nettype none
module swgf_top_tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, peer_bit = 1'b0;
  logic lane_tick = 1'b0, grant_tick = 1'b0, status_tick = 1'b0;
  swgf_pkg::swgf_uc_mode_t uc_mode = swgf_pkg::UC_SPLIT;
  wire logic [1:0] unicast_grant_a, unicast_grant_b;
  wire logic [1:0] multicast_grant_a, multicast_grant_b;
  logic [7:0] rx_space_a = 8'h10, rx_space_b = 8'h10;
  logic [7:0] rx_space_min = 8'h10, tx_word_a = 8'h00, rx_cmd = 8'h5a;
  logic [7:0] free_q_count = 8'h00, free_q_threshold = 8'h20;
  logic tx_valid_a = 1'b0, tx_mc_a = 1'b0, sync_source = 1'b1;
  logic [1:0] tx_prio_a = 2'h0, g_cmd = 2'h0;
  logic [3:0] my_slot = 4'h3;
  logic [15:0] egress_rate_avg = 16'h0100, egress_rate_limit = 16'h0080;
  wire logic [7:0] tx_word_b = tx_word_a;
  wire logic tx_valid_b = tx_valid_a, tx_mc_b = tx_mc_a;
  wire logic [1:0] tx_prio_b = tx_prio_a;
  wire logic send_grant_a, send_grant_b, tx_ready_a, tx_ready_b;
  wire logic rx_word_valid_a, rx_word_valid_b, ingress_buffers_low;
  wire logic [7:0] cell_tx_lanes_a, cell_tx_lanes_b, rx_word_a, rx_word_b;
  wire logic [7:0] cell_rx_lanes_a, cell_rx_lanes_b;
  wire logic peer_status_frame_sync_out, peer_status_frame_sync_oe;
  wire logic peer_status_line_out, peer_status_line_oe;
  wire logic [15:0] peer_congested;
  // Released lines show the peer level peer_bit, not the value last driven
  wire logic peer_status_frame_sync_in =
    peer_status_frame_sync_oe ? peer_status_frame_sync_out : peer_bit;
  wire logic peer_status_line_in =
    peer_status_line_oe ? peer_status_line_out : peer_bit;
  int bad_count = 0, compares = 0;
  always #2.5 clock = ~clock;
  swgf_top i_dut (.clock, .sys_rst, .lane_tick, .grant_tick, .uc_mode,
    .unicast_grant_a, .unicast_grant_b, .multicast_grant_a,
    .multicast_grant_b, .send_grant_a, .send_grant_b, .rx_space_a,
    .rx_space_b, .rx_space_min, .cell_tx_lanes_a, .cell_tx_lanes_b,
    .cell_rx_lanes_a, .cell_rx_lanes_b, .tx_word_a, .tx_word_b,
    .tx_valid_a, .tx_valid_b, .tx_mc_a, .tx_mc_b, .tx_prio_a, .tx_prio_b,
    .tx_ready_a, .tx_ready_b, .rx_word_a, .rx_word_b, .rx_word_valid_a,
    .rx_word_valid_b, .free_q_count, .free_q_threshold,
    .ingress_buffers_low, .status_tick, .sync_source, .my_slot,
    .egress_rate_avg, .egress_rate_limit, .peer_status_frame_sync_in,
    .peer_status_frame_sync_out, .peer_status_frame_sync_oe,
    .peer_status_line_in, .peer_status_line_out, .peer_status_line_oe,
    .peer_congested);
  swgf_fabric_model i_fab_a (.clock, .grant_tick, .grant_cmd(g_cmd),
    .cell_cmd(rx_cmd), .send_grant(send_grant_a),
    .unicast_grant(unicast_grant_a), .multicast_grant(multicast_grant_a),
    .cell_lanes(cell_rx_lanes_a));
  swgf_fabric_model i_fab_b (.clock, .grant_tick, .grant_cmd(g_cmd),
    .cell_cmd(rx_cmd), .send_grant(send_grant_b),
    .unicast_grant(unicast_grant_b), .multicast_grant(multicast_grant_b),
    .cell_lanes(cell_rx_lanes_b));
  task automatic close_out;
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic gpulse;
    @(posedge clock);
    grant_tick <= 1'b1;
    @(posedge clock);
    grant_tick <= 1'b0;
  endtask
  task automatic t_grant;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      rx_space_a <= rx_space_min - 8'(i);
      rx_space_b <= rx_space_min - 8'(1 - i);
      gpulse();
      @(posedge clock);
      #1;
      chk("send_grant_a", 16'(i == 0), 16'(send_grant_a));
      chk("send_grant_b", 16'(i == 1), 16'(send_grant_b));
    end
  endtask
  // Mode 0 split unicast, 1 combined unicast, 2 multicast
  task automatic t_perm;
    logic e;
    logic [7:0] w;
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++)
        for (int p = 0; p < 3; p++)
        begin
          w = {2'h2, 2'(m), 2'(c), 2'(p)};
          e = (m == 1) ? c[0] : (p < 2 ? c[0] : c[1]);
          @(posedge clock);
          uc_mode <= swgf_pkg::swgf_uc_mode_t'(m == 1);
          g_cmd <= 2'(c);
          repeat (2) gpulse();
          @(posedge clock);
          tx_word_a <= w;
          tx_valid_a <= 1'b1;
          tx_mc_a <= (m == 2);
          tx_prio_a <= 2'(p);
          lane_tick <= 1'b1;
          #1;
          chk("tx_ready_a", 16'(e), 16'(tx_ready_a));
          chk("tx_ready_b", 16'(e), 16'(tx_ready_b));
          @(posedge clock);
          tx_valid_a <= 1'b0;
          lane_tick <= 1'b0;
          #1;
          chk("lanes_a", 16'(e ? w : 8'h00), 16'(cell_tx_lanes_a));
          chk("lanes_b", 16'(e ? w : 8'h00), 16'(cell_tx_lanes_b));
          chk("rx_word_a", 16'h0, 16'(rx_word_a));
          chk("rx_word_b", 16'(rx_cmd), 16'(rx_word_b));
          chk("rx_valid_a", 16'h1, 16'(rx_word_valid_a));
          chk("rx_valid_b", 16'h1, 16'(rx_word_valid_b));
        end
  endtask
  task automatic t_thresh;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      free_q_count <= free_q_threshold + 8'(i);
      repeat (2) @(posedge clock);
      #1;
      chk("buffers_low", 16'(i), 16'(ingress_buffers_low));
    end
  endtask
  task automatic t_status;
    logic [3:0] s;
    for (int r = 0; r < 2; r++)
    begin
      @(posedge clock);
      egress_rate_avg <= (r == 0) ? 16'h0100 : egress_rate_limit;
      for (int i = 1; i <= 16; i++)
      begin
        @(posedge clock);
        status_tick <= 1'b1;
        peer_bit <= ~peer_bit;
        @(posedge clock);
        status_tick <= 1'b0;
        #1;
        s = 4'(i);
        chk("sync_out", 16'(i == 16), 16'(peer_status_frame_sync_out));
        chk("sync_oe", 16'h1, 16'(peer_status_frame_sync_oe));
        chk("line_oe", 16'(s == my_slot), 16'(peer_status_line_oe));
        chk("line_out", 16'(s == my_slot && r == 0),
          16'(peer_status_line_out));
      end
      // Even slots saw the peer level high, slot 3 is our own bit
      chk("congested", r ? 16'h5555 : 16'h555d, peer_congested);
    end
    @(posedge clock);
    sync_source <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("sync_oe_off", 16'h0, 16'(peer_status_frame_sync_oe));
    // Follower: a sync seen at the sixth tick restarts the slot count
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clock);
      status_tick <= 1'b1;
      peer_bit <= (i == 5);
      @(posedge clock);
      status_tick <= 1'b0;
      #1;
      chk("follow_oe", 16'(i == 2 || i == 8), 16'(peer_status_line_oe));
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset_grant", 16'h0, 16'(send_grant_a));
    t_grant();
    t_perm();
    t_thresh();
    t_status();
    close_out();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    close_out();
  end
endmodule
bind swgf_top swgf_sva i_sva (.clock, .sys_rst, .lane_tick, .grant_tick,
  .status_tick, .rx_word_valid_a,
  .rx_space_a, .rx_space_min, .send_grant_a, .multicast_grant_a,
  .tx_valid_a, .tx_mc_a, .tx_ready_a, .cell_tx_lanes_a, .free_q_count,
  .free_q_threshold, .ingress_buffers_low, .sync_source,
  .peer_status_frame_sync_out, .peer_status_frame_sync_oe,
  .peer_status_line_out, .peer_status_line_oe);
`default_nettype wire
